// ===== dcfg_channel_config.sv
// Configuration registers of a two-group, eight-slot DMA controller: group command, channel mode, extended mode.
// Assumes the host I/O decoder presents one write strobe per I/O cycle with address and byte, synchronous to sys_clk.
//
// Notes on behaviour
// RULE_01: All control registers written through host I/O.
// RULE_02: System reset restores every register default.
// RULE_03: Command register write-only, cleared by reset/master clear.
// RULE_04: Upper group disable also stops lower group.
// RULE_05: Command bit 7 sets acknowledge polarity.
// RULE_06: Command bit 6 sets request sense polarity.
// RULE_07: Command bit 4 selects rotating or fixed priority.
// RULE_08: Command bit 2 disables group when set.
// RULE_09: Software writes zero to reserved command bits.
// RULE_10: Mode bits 7:6 choose transfer mode.
// RULE_11: Channel 4 stays in cascade mode always.
// RULE_12: Mode bit 5 selects address decrement.
// RULE_13: Mode bit 4 enables autoinitialization.
// RULE_14: Mode bits 3:2 transfer type, ignored in cascade.
// RULE_15: Mode bits 1:0 select target channel.
// RULE_16: Extended bits 1:0 select channel, not stored.
// RULE_17: Expansion memory cycles fall back to compatible timing.
// RULE_18: Only system reset loads extended defaults.
// RULE_19: Lower 8-bit bytes, upper 16-bit words defaults.
// RULE_20: Extended bit 6 sets end-of-process direction.
// RULE_21: End-of-process direction follows acknowledge changes.
// RULE_22: During direction overlap drive line only low.
// RULE_23: Extended bits 5:4 select cycle timing.
// RULE_24: Cascade channel only passes request and acknowledge.
`timescale 1ns/1ps
`default_nettype none

module dcfg_channel_config
	import dcfg_pkg::*;
#(
	parameter int CHANNELS = DCFG_CHANNELS
) (
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	input  wire logic                 clk_en,
	input  wire logic                 io_wr,
	input  wire logic [15:0]          io_addr,
	input  wire logic [7:0]           io_wdata,
	input  wire logic                 master_clear_low,
	input  wire logic                 master_clear_high,
	input  wire logic                 cfg_ready,
	input  wire logic [CHANNELS-1:0]  request_input,
	input  wire logic [CHANNELS-1:0]  grant,
	input  wire logic                 target_is_expansion,
	input  wire logic                 eop_drive_level,
	output logic                      cfg_valid,
	output dcfg_chan_cfg_t            cfg_out,
	output logic [2:0]                cfg_channel,
	output logic [CHANNELS-1:0]       request_active,
	output logic [CHANNELS-1:0]       acknowledge_output,
	output logic                      eop_out,
	output logic                      eop_oe_n,
	output logic                      eop_is_input,
	output logic [1:0]                effective_timing,
	output logic                      rotating_low,
	output logic                      rotating_high
);

	typedef struct packed {
		logic [7:0]              cmd_low;
		logic [7:0]              cmd_high;
		dcfg_mode_t [CHANNELS-1:0] mode;
		dcfg_ext_t  [CHANNELS-1:0] ext;
		logic [2:0]              scan;
		logic                    buf_valid0;
		logic                    buf_valid1;
		dcfg_chan_cfg_t          buf_data0;
		dcfg_chan_cfg_t          buf_data1;
		logic [2:0]              buf_ch0;
		logic [2:0]              buf_ch1;
		logic [CHANNELS-1:0]     last_grant;
		logic [CHANNELS-1:0]     req_act;
		logic [CHANNELS-1:0]     ack;
		logic                    eop_out;
		logic                    eop_oe_n;
		logic                    eop_in_sel;
		logic [1:0]              eff_timing;
	} dcfg_state_t;

	dcfg_state_t cur;
	dcfg_state_t next_cur;

	// Group of a slot: upper half uses the upper command register.
	function automatic logic [7:0] dcfg_group_cmd(input dcfg_state_t s, input logic [2:0] ch);
		dcfg_group_cmd = ch[2] ? s.cmd_high : s.cmd_low;
	endfunction : dcfg_group_cmd

	function automatic logic dcfg_enabled(input dcfg_state_t s, input logic [2:0] ch);
		logic [7:0] own_cmd;
		logic       up_en;
		logic       own_en;
		own_cmd = dcfg_group_cmd(s, ch);
		up_en   = ~s.cmd_high[DCFG_CMD_DISABLE_BIT]; // RULE_08
		own_en  = ~own_cmd[DCFG_CMD_DISABLE_BIT];
		dcfg_enabled = up_en & own_en; // RULE_04
	endfunction : dcfg_enabled

	function automatic dcfg_chan_cfg_t dcfg_summary(input dcfg_state_t s, input logic [2:0] ch);
		dcfg_chan_cfg_t r;
		r.xfer_mode    = s.mode[ch].xfer_mode; // RULE_10
		r.decrement    = s.mode[ch].decrement; // RULE_12
		r.auto_init    = s.mode[ch].auto_init; // RULE_13
		r.xfer_type    = s.mode[ch].xfer_type;
		r.type_valid   = (s.mode[ch].xfer_mode != DCFG_MODE_CASCADE) &&
		                 (s.mode[ch].xfer_type != DCFG_TYPE_ILLEGAL); // RULE_14
		r.timing       = s.ext[ch].timing; // RULE_23
		r.data_size    = s.ext[ch].data_size;
		r.eop_input    = s.ext[ch].eop_input; // RULE_20
		r.enabled      = dcfg_enabled(s, ch);
		r.cascade_only = (s.mode[ch].xfer_mode == DCFG_MODE_CASCADE); // RULE_24
		dcfg_summary = r;
	endfunction : dcfg_summary

	always_comb begin
		logic [2:0] ch;
		logic       pop;
		logic       push;
		logic [7:0] gc;
		ch       = 3'h0;
		pop      = 1'b0;
		push     = 1'b0;
		gc       = 8'h00;
		next_cur = cur;

		// Register writes from the host I/O port.
		if (io_wr) begin // RULE_01
			if (io_addr == DCFG_OFF_CMD_LOW) begin
				next_cur.cmd_low = io_wdata; // RULE_03
			end else if (io_addr == DCFG_OFF_CMD_HIGH) begin
				next_cur.cmd_high = io_wdata;
			end else if (io_addr == DCFG_OFF_MODE_LOW || io_addr == DCFG_OFF_MODE_HIGH) begin
				ch = {io_addr == DCFG_OFF_MODE_HIGH, io_wdata[1:0]}; // RULE_15
				next_cur.mode[ch] = dcfg_mode_t'(io_wdata[7:2]);
				if (ch == 3'h4) begin
					next_cur.mode[ch].xfer_mode = DCFG_MODE_CASCADE; // RULE_11
				end
			end else if (io_addr == DCFG_OFF_EXT_LOW || io_addr == DCFG_OFF_EXT_HIGH) begin
				ch = {io_addr == DCFG_OFF_EXT_HIGH, io_wdata[1:0]};
				next_cur.ext[ch] = dcfg_ext_t'(io_wdata[7:2]); // RULE_16
			end
		end

		// Master clear clears the command register but never the extended settings.
		if (master_clear_low) begin
			next_cur.cmd_low = DCFG_CMD_RESET; // RULE_03 RULE_18
		end
		if (master_clear_high) begin
			next_cur.cmd_high = DCFG_CMD_RESET;
		end

		// Two-entry buffer of per-channel summaries; the consumer may stall without losing one.
		pop = cur.buf_valid0 & cfg_ready;
		push = ~cur.buf_valid1 | pop;
		if (pop) begin
			next_cur.buf_valid0 = cur.buf_valid1;
			next_cur.buf_data0  = cur.buf_data1;
			next_cur.buf_ch0    = cur.buf_ch1;
			next_cur.buf_valid1 = 1'b0;
		end
		if (push) begin
			if (!next_cur.buf_valid0) begin
				next_cur.buf_valid0 = 1'b1;
				next_cur.buf_data0  = dcfg_summary(cur, cur.scan);
				next_cur.buf_ch0    = cur.scan;
			end else begin
				next_cur.buf_valid1 = 1'b1;
				next_cur.buf_data1  = dcfg_summary(cur, cur.scan);
				next_cur.buf_ch1    = cur.scan;
			end
			next_cur.scan = cur.scan + 3'h1;
		end

		// Request sense and acknowledge polarity, per group.
		for (int i = 0; i < CHANNELS; i++) begin
			gc = dcfg_group_cmd(cur, 3'(i));
			next_cur.req_act[i] = (request_input[i] ^ gc[DCFG_CMD_REQ_LOW_BIT]) &
			                      dcfg_enabled(cur, 3'(i)); // RULE_06 RULE_04
			next_cur.ack[i] = (grant[i] & dcfg_enabled(cur, 3'(i))) ~^ gc[DCFG_CMD_ACK_HIGH_BIT]; // RULE_05
		end

		// End-of-process direction changes only when the grant vector changes, including to or from no grant.
		next_cur.last_grant = grant;
		if (grant != cur.last_grant) begin // RULE_21
			next_cur.eop_in_sel = 1'b0;
			next_cur.eop_out    = 1'b0; // RULE_22
			next_cur.eop_oe_n   = 1'b0;
			for (int i = 0; i < CHANNELS; i++) begin
				if (grant[i]) begin
					next_cur.eop_in_sel = cur.ext[i].eop_input; // RULE_20
				end
			end
		end else begin
			// The line is released only after one cycle driven low, so the overlap stays at the inactive level.
			next_cur.eop_oe_n = cur.eop_in_sel;
			next_cur.eop_out  = ~cur.eop_in_sel & eop_drive_level;
		end

		// Extended timing is for main memory only.
		next_cur.eff_timing = DCFG_TIME_COMPAT;
		for (int i = 0; i < CHANNELS; i++) begin
			if (grant[i] && !target_is_expansion) begin
				next_cur.eff_timing = cur.ext[i].timing; // RULE_17
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cur <= '0; // RULE_02
			for (int i = 0; i < CHANNELS; i++) begin
				cur.mode[i] <= dcfg_mode_t'(DCFG_MODE_RESET);
				cur.ext[i]  <= dcfg_ext_t'((i >= 4) ? DCFG_EXT_RESET_HIGH : DCFG_EXT_RESET_LOW); // RULE_19 RULE_18
			end
			cur.mode[4].xfer_mode <= DCFG_MODE_CASCADE; // RULE_11
			cur.ack               <= '1; // Active-low acknowledge idles high.
			cur.eop_oe_n          <= 1'b0;
		end else if (clk_en) begin
			cur <= next_cur;
		end
	end

	assign cfg_valid          = cur.buf_valid0;
	assign cfg_out            = cur.buf_data0;
	assign cfg_channel        = cur.buf_ch0;
	assign request_active     = cur.req_act;
	assign acknowledge_output = cur.ack;
	assign eop_out            = cur.eop_out;
	assign eop_oe_n           = cur.eop_oe_n;
	assign eop_is_input       = cur.eop_in_sel;
	assign effective_timing   = cur.eff_timing;
	assign rotating_low       = cur.cmd_low[DCFG_CMD_ROTATE_BIT]; // RULE_07
	assign rotating_high      = cur.cmd_high[DCFG_CMD_ROTATE_BIT];

endmodule : dcfg_channel_config

`default_nettype wire

// ===== dcfg_pkg.sv
// Package for the DMA channel configuration block: register offsets, field positions, reset values, types.
// Assumes a decoded host I/O write port with a 16-bit I/O address and 8-bit data.
package dcfg_pkg;

	localparam logic [15:0] DCFG_OFF_CMD_LOW   = 16'h0008;
	localparam logic [15:0] DCFG_OFF_MODE_LOW  = 16'h000b;
	localparam logic [15:0] DCFG_OFF_CMD_HIGH  = 16'h00d0;
	localparam logic [15:0] DCFG_OFF_MODE_HIGH = 16'h00d6;
	localparam logic [15:0] DCFG_OFF_EXT_LOW   = 16'h040b;
	localparam logic [15:0] DCFG_OFF_EXT_HIGH  = 16'h04d6;

	localparam int DCFG_CMD_ACK_HIGH_BIT = 7;
	localparam int DCFG_CMD_REQ_LOW_BIT  = 6;
	localparam int DCFG_CMD_ROTATE_BIT   = 4;
	localparam int DCFG_CMD_DISABLE_BIT  = 2;

	localparam logic [7:0] DCFG_CMD_RESET      = 8'h00;
	localparam logic [5:0] DCFG_MODE_RESET     = 6'h00;
	localparam logic [5:0] DCFG_EXT_RESET_LOW  = 6'h00;
	localparam logic [5:0] DCFG_EXT_RESET_HIGH = 6'h01;

	localparam logic [1:0] DCFG_MODE_DEMAND  = 2'h0;
	localparam logic [1:0] DCFG_MODE_SINGLE  = 2'h1;
	localparam logic [1:0] DCFG_MODE_BLOCK   = 2'h2;
	localparam logic [1:0] DCFG_MODE_CASCADE = 2'h3;

	localparam logic [1:0] DCFG_TYPE_VERIFY  = 2'h0;
	localparam logic [1:0] DCFG_TYPE_WRITE   = 2'h1;
	localparam logic [1:0] DCFG_TYPE_READ    = 2'h2;
	localparam logic [1:0] DCFG_TYPE_ILLEGAL = 2'h3;

	localparam logic [1:0] DCFG_TIME_COMPAT = 2'h0;

	localparam int DCFG_CHANNELS = 8;

	typedef struct packed {
		logic [1:0] xfer_mode;
		logic       decrement;
		logic       auto_init;
		logic [1:0] xfer_type;
	} dcfg_mode_t;

	typedef struct packed {
		logic       reserved;
		logic       eop_input;
		logic [1:0] timing;
		logic [1:0] data_size;
	} dcfg_ext_t;

	typedef struct packed {
		logic       ack_active_high;
		logic       req_active_low;
		logic       rotating;
		logic       group_enabled;
	} dcfg_group_t;

	typedef struct packed {
		logic [1:0] xfer_mode;
		logic       decrement;
		logic       auto_init;
		logic [1:0] xfer_type;
		logic       type_valid;
		logic [1:0] timing;
		logic [1:0] data_size;
		logic       eop_input;
		logic       enabled;
		logic       cascade_only;
	} dcfg_chan_cfg_t;

endpackage : dcfg_pkg

// ===== dcfg_asserts.sv
// Concurrent checks on the ports of the DMA channel configuration block.
// Assumes clk_en is held high, so every edge is an active one.
`timescale 1ns/1ps
`default_nettype none
module dcfg_asserts
	import dcfg_pkg::*;
#(
	parameter int CHANNELS = DCFG_CHANNELS
) (
	input wire logic                sys_clk,
	input wire logic                rst,
	input wire logic                io_wr,
	input wire logic [15:0]         io_addr,
	input wire logic [7:0]          io_wdata,
	input wire logic                master_clear_high,
	input wire logic                cfg_ready,
	input wire logic [CHANNELS-1:0] grant,
	input wire logic                target_is_expansion,
	input wire logic                eop_drive_level,
	input wire logic                cfg_valid,
	input wire dcfg_chan_cfg_t      cfg_out,
	input wire logic [2:0]          cfg_channel,
	input wire logic [CHANNELS-1:0] request_active,
	input wire logic                eop_out,
	input wire logic                eop_oe_n,
	input wire logic                eop_is_input,
	input wire logic [1:0]          effective_timing,
	input wire logic                rotating_high
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence pop_s; cfg_valid && cfg_ready; endsequence
	sequence swap_s; $changed(grant); endsequence
	sequence hi_wr_s; io_wr && io_addr == DCFG_OFF_CMD_HIGH && !master_clear_high; endsequence
	cfg_hold_a: assert property (cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_out) && $stable(cfg_channel))
		else $error("config word changed under stall");
	cfg_order_a: assert property (pop_s ##1 cfg_valid |-> cfg_channel == $past(cfg_channel) + 3'h1)
		else $error("config slot order broken");
	casc_slot_a: assert property (cfg_valid && cfg_channel == 3'h4 |-> cfg_out.xfer_mode == DCFG_MODE_CASCADE)
		else $error("slot four left cascade mode");
	casc_type_a: assert property (cfg_valid && cfg_out.xfer_mode == DCFG_MODE_CASCADE |-> !cfg_out.type_valid)
		else $error("transfer type used in cascade");
	eop_low_a: assert property (swap_s |=> !eop_out && !eop_oe_n)
		else $error("end of process not low at swap");
	eop_dir_a: assert property (swap_s ##1 $stable(grant) |=> eop_oe_n == eop_is_input)
		else $error("end of process direction wrong");
	exp_time_a: assert property (target_is_expansion [*2] |-> effective_timing == DCFG_TIME_COMPAT)
		else $error("fast timing to expansion memory");
	rot_wr_a: assert property (hi_wr_s |=> rotating_high == $past(io_wdata[4]))
		else $error("rotating flag not written");
	mclr_cmd_a: assert property (master_clear_high |=> !rotating_high)
		else $error("master clear left command set");
	grp_off_a: assert property (hi_wr_s ##0 io_wdata[2] |=> ##1 request_active == '0)
		else $error("requests pass a disabled group");
	eop_drv_a: assert property (!swap_s |=> eop_out == (!$past(eop_is_input) && $past(eop_drive_level)))
		else $error("end of process output level wrong");
endmodule : dcfg_asserts
bind dcfg_channel_config dcfg_asserts #(.CHANNELS(CHANNELS)) u_dcfg_asserts (.sys_clk, .rst, .io_wr, .io_addr,
	.io_wdata, .master_clear_high, .cfg_ready, .grant, .target_is_expansion, .eop_drive_level, .cfg_valid, .cfg_out,
	.cfg_channel,
	.request_active, .eop_out, .eop_oe_n, .eop_is_input, .effective_timing, .rotating_high);
`default_nettype wire

// ===== dcfg_slave_model.sv
// Request side of the DMA slave peripherals.
// Assumes the bench chooses which slots want service and the sense level.
`timescale 1ns/1ps
`default_nettype none
module dcfg_slave_model (
	input  wire logic       sys_clk,
	input  wire logic       req_low,
	input  wire logic [7:0] want,
	output logic [7:0]      request_input
);
	// Requests move only after an edge, as a real slave's would.
	always_ff @(posedge sys_clk) begin
		request_input <= req_low ? ~want : want;
	end
endmodule : dcfg_slave_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the DMA channel configuration block.
// Assumes the slave model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import dcfg_pkg::*;
	typedef struct packed {logic [2:0] ch; logic [13:0] v;} dcfg_note_t;
	logic sys_clk, rst, io_wr, master_clear_low, master_clear_high, cfg_ready, target_is_expansion;
	logic eop_drive_level, req_low, cfg_valid, eop_out, eop_oe_n, eop_is_input, rotating_low, rotating_high;
	logic [15:0] io_addr;
	logic [7:0] io_wdata, grant, want, request_input, request_active, acknowledge_output;
	logic [2:0] cfg_channel;
	logic [1:0] effective_timing;
	dcfg_chan_cfg_t cfg_out;
	logic [31:0] lf = 32'h00000020;
	logic [5:0] md [8];
	logic [5:0] ex [8];
	dcfg_note_t q [$];
	int bad_count, checked, pops;
	dcfg_channel_config u_dcfg_channel_config (.sys_clk, .rst, .clk_en(1'h1), .io_wr, .io_addr, .io_wdata,
		.master_clear_low, .master_clear_high, .cfg_ready, .request_input, .grant, .target_is_expansion,
		.eop_drive_level, .cfg_valid, .cfg_out, .cfg_channel, .request_active, .acknowledge_output, .eop_out,
		.eop_oe_n, .eop_is_input, .effective_timing, .rotating_low, .rotating_high);
	dcfg_slave_model u_dcfg_slave_model (.sys_clk, .req_low, .want, .request_input);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic complete_run;
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic [2:0] c;
		c = {a == DCFG_OFF_MODE_HIGH || a == DCFG_OFF_EXT_HIGH, d[1:0]};
		@(posedge sys_clk);
		io_wr <= 1'h1;
		io_addr <= a;
		io_wdata <= d;
		@(posedge sys_clk);
		io_wr <= 1'h0;
		if (a == DCFG_OFF_MODE_LOW || a == DCFG_OFF_MODE_HIGH) md[c] = (c == 3'h4) ? {2'h3, d[5:2]} : d[7:2];
		if (a == DCFG_OFF_EXT_LOW || a == DCFG_OFF_EXT_HIGH) ex[c] = d[7:2];
	endtask : wr
	task automatic settle;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask : settle
	// Old words may still sit in the buffer, so notes wait until it has turned over.
	task automatic push_all;
		int n;
		n = pops + 4;
		while (pops < n) @(posedge sys_clk);
		for (int i = 0; i < 8; i++) q.push_back({3'(i), md[i], ex[i][3:0], ex[i][4], 1'h1,
			md[i][5:4] != 2'h3 && md[i][1:0] != 2'h3, md[i][5:4] == 2'h3});
		while (q.size() != 0) @(posedge sys_clk);
	endtask : push_all
	always @(posedge sys_clk) begin
		lf <= lfsr(lf);
		cfg_ready <= lf[0] | lf[1];
		eop_drive_level <= lf[2];
		if (!rst && cfg_valid === 1'h1 && cfg_ready) begin
			pops++;
			if (q.size() > 0 && cfg_channel === q[0].ch) begin
				chk({cfg_out.xfer_mode, cfg_out.decrement, cfg_out.auto_init, cfg_out.xfer_type, cfg_out.timing,
					cfg_out.data_size, cfg_out.eop_input, cfg_out.enabled, cfg_out.type_valid,
					cfg_out.cascade_only}, q[0].v);
				void'(q.pop_front());
			end
		end
	end
	initial begin
		sys_clk = 1'h0;
		forever #4 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		complete_run();
	end
	initial begin
		{rst, io_wr, master_clear_low, master_clear_high, target_is_expansion, req_low} = 6'h20;
		{cfg_ready, eop_drive_level, io_addr, io_wdata, grant, want} = 42'h0;
		for (int i = 0; i < 8; i++) begin
			md[i] = (i == 4) ? 6'h30 : 6'h00;
			ex[i] = (i > 3) ? 6'h01 : 6'h00;
		end
		repeat (3) @(posedge sys_clk);
		rst <= 1'h0;
		push_all();
		for (int i = 0; i < 16; i++) begin
			wr(lf[6] ? DCFG_OFF_MODE_HIGH : DCFG_OFF_MODE_LOW, {i[1:0], lf[5:4], i[3:2], lf[1:0]});
			wr(lf[7] ? DCFG_OFF_EXT_HIGH : DCFG_OFF_EXT_LOW, {1'h0, lf[9], i[1:0], lf[11:10], lf[13:12]});
		end
		wr(16'h000c, 8'hff);
		push_all();
		wr(DCFG_OFF_CMD_HIGH, 8'h10);
		wr(DCFG_OFF_CMD_LOW, 8'h10);
		settle();
		chk({rotating_high, rotating_low}, 2'h3);
		@(posedge sys_clk);
		{master_clear_low, master_clear_high} <= 2'h3;
		@(posedge sys_clk);
		{master_clear_low, master_clear_high} <= 2'h0;
		settle();
		chk({rotating_high, rotating_low}, 2'h0);
		push_all();
		@(posedge sys_clk);
		want <= 8'h0f;
		grant <= 8'h02;
		settle();
		chk(request_active & 8'hef, 8'h0f);
		chk(acknowledge_output, 8'hfd);
		@(posedge sys_clk);
		req_low <= 1'h1;
		wr(DCFG_OFF_CMD_LOW, 8'hc0);
		wr(DCFG_OFF_CMD_HIGH, 8'hc0);
		settle();
		chk(request_active & 8'hef, 8'h0f);
		chk(acknowledge_output, 8'h02);
		wr(DCFG_OFF_CMD_HIGH, 8'hc4);
		settle();
		chk({request_active, acknowledge_output}, 16'h0000);
		wr(DCFG_OFF_CMD_HIGH, 8'h00);
		wr(DCFG_OFF_EXT_LOW, 8'h41);
		wr(DCFG_OFF_EXT_LOW, 8'h16);
		@(posedge sys_clk);
		grant <= 8'h04;
		settle();
		chk({eop_is_input, eop_oe_n, effective_timing}, 4'h1);
		@(posedge sys_clk);
		grant <= 8'h02;
		target_is_expansion <= 1'h1;
		settle();
		chk({eop_is_input, eop_oe_n, effective_timing}, 4'hc);
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
